// ### bench/ftbs_wire_model.sv
/*
  controller side of the data wire: drives write data, resolves the pins.
  assumes dq_oe high means the port drives the wire.
*/
`timescale 1ns/10ps
module ftbs_wire_model (
  // clock
  input wire logic ref_clk,
  // port side
  input wire logic [35:0] dq_out,
  input wire logic dq_oe,
  // controller side
  input wire logic [35:0] host_d,
  input wire logic host_en,
  output logic [35:0] dq_in
);
  logic [35:0] last_r;
  // released wire shows the inverse of its last value, never a stale copy
  always_ff @(posedge ref_clk) last_r <= dq_in;
  assign dq_in = dq_oe ? dq_out : (host_en ? host_d : ~last_r);
endmodule

// ### bench/tb_flow_through_burst_sram_port.sv
/*
  self-checking bench for ftbs_port: bursts, lanes, gating, select, oe.
  assumes the wire model resolves the data pins; address shrunk to 6 bits.
*/
`timescale 1ns/10ps
module tb_flow_through_burst_sram_port;
  // ctl codes: adv, we_n, cs1_n, cs2, cs3_n
  localparam logic [4:0] RD = 5'h0a;
  localparam logic [4:0] WR = 5'h02;
  localparam logic [4:0] ADV = 5'h1a;
  localparam logic [4:0] PS = 5'h08;
  localparam logic [35:0] M = 36'hf_ffff_fe00;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clock_gate_n = 1'b0;
  logic [5:0] addr = 6'h00;
  ftbs_pkg::ftbs_ctl_t ctl = 5'h0e;
  logic [3:0] byte_lane_write_n = 4'hf;
  logic burst_order = 1'b1;
  logic oe_n = 1'b0;
  logic [35:0] host_d = 36'h0;
  logic host_en = 1'b0;
  logic [35:0] dq_in;
  logic [35:0] dq_out;
  logic dq_oe;
  int checks = 0;
  int miscompares = 0;
  always #25 ref_clk = ~ref_clk;
  ftbs_port #(.ADDR_W(6)) dut (.ref_clk(ref_clk), .rst(rst), .clock_gate_n(clock_gate_n),
    .addr(addr), .ctl(ctl), .byte_lane_write_n(byte_lane_write_n),
    .burst_order(burst_order), .oe_n(oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  ftbs_wire_model wm (.ref_clk(ref_clk), .dq_out(dq_out), .dq_oe(dq_oe),
    .host_d(host_d), .host_en(host_en), .dq_in(dq_in));
  // distinct word per address, lane 0 carries the address
  function automatic logic [35:0] wd(input logic [5:0] a);
    return 36'h5_a3c1_0000 | 36'(a);
  endfunction
  task automatic chk(input logic [35:0] exp, input logic [35:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // one command per edge, write data rides with the next command
  task automatic step(input logic [4:0] c, input logic [5:0] a, input logic [3:0] bw,
                      input logic den, input logic [35:0] d);
    @(negedge ref_clk);
    ctl <= c;
    addr <= a;
    byte_lane_write_n <= bw;
    host_en <= den;
    host_d <= d;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic burst_scn(input logic order);
    @(negedge ref_clk);
    rst <= 1'b1;
    burst_order <= order;
    repeat (6) @(negedge ref_clk);
    rst <= 1'b0;
    for (int i = 4; i < 8; i++) begin
      step(WR, 6'(i), 4'h0, i > 4, wd(6'(i - 1)));
      chk(36'h0, 36'(dq_oe));
    end
    step(RD, 6'h05, 4'hf, 1'b1, wd(6'h07));
    chk(36'h1, 36'(dq_oe));
    for (int k = 0; k < 4; k++) begin
      chk(wd(order ? 6'h05 ^ 6'(k) : {4'h1, 2'(2'h1 + 2'(k))}), dq_out);
      if (k < 3) step(ADV, 6'h00, 4'hf, 1'b0, 36'h0);
    end
  endtask
  task automatic lane_scn();
    step(WR, 6'h04, 4'he, 1'b0, 36'h0);
    step(RD, 6'h04, 4'h0, 1'b1, 36'h0);
    chk(wd(6'h04) & M, dq_out);
  endtask
  task automatic gate_scn();
    @(negedge ref_clk);
    clock_gate_n <= 1'b1;
    ctl <= PS;
    @(posedge ref_clk);
    #1;
    chk(wd(6'h04) & M, dq_out);
    chk(36'h1, 36'(dq_oe));
    @(negedge ref_clk);
    oe_n <= 1'b1;
    #1;
    chk(36'h0, 36'(dq_oe));
    @(negedge ref_clk);
    oe_n <= 1'b0;
    clock_gate_n <= 1'b0;
    #1;
    chk(36'h1, 36'(dq_oe));
  endtask
  task automatic desel_scn();
    step(PS, 6'h05, 4'hf, 1'b0, 36'h0);
    chk(36'h0, 36'(dq_oe));
    step(ADV, 6'h05, 4'hf, 1'b0, 36'h0);
    chk(36'h0, 36'(dq_oe));
    step(RD, 6'h04, 4'hf, 1'b0, 36'h0);
    chk(wd(6'h04) & M, dq_out);
  endtask
  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    burst_scn(1'b0);
    burst_scn(1'b1);
    lane_scn();
    gate_scn();
    desel_scn();
    end_sim();
  end
  // watchdog, ten times the expected run
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
endmodule

// ### include/ftbs_pkg.sv
/*
  shared constants and types for the flow-through burst memory port.
  assumes one rising-edge clock and synchronous pin sampling everywhere except the asynchronous oe_n.
*/
package ftbs_pkg;
  // storage shape: 512K words of four 9-bit byte lanes (parity bit per lane)
  localparam int ADDR_W = 19;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = LANE_W * LANES;
  // the two low address bits feed the burst counter
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  // reset values
  localparam logic [BURST_W-1:0] CNT_RST = 2'h0;
  localparam logic BURST_ORDER_RST = 1'b1;

  // access state of the command pipeline, one-hot
  typedef enum logic [2:0] {
    FTBS_DESEL = 3'b001,
    FTBS_READ = 3'b010,
    FTBS_WRITE = 3'b100
  } ftbs_state_t;

  // synchronous control pins sampled together at each edge
  typedef struct packed {
    logic advance_or_load;
    logic write_strobe_n;
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
  } ftbs_ctl_t;
endpackage

// ### verilog/ftbs_port.sv
/*
  pin-level logic of a flow-through burst static memory: command capture,
  burst counter, byte-lane writes, chip select, clock gating and data pin
  direction. assumes the controller drives every pin but oe_n synchronous to ref_clk
  and resolves the data wire from dq_oe outside this module.
*/
// Behaviour
// R1: capture address on qualified edge, select location
// R2: low two address bits seed burst counter
// R3: byte-lane writes active low, need write strobe
// R4: write strobe sampled only while clock gated open
// R5: controller drops write strobe to start writes
// R6: advance high steps burst counter
// R7: advance low loads fresh address
// R8: controller loads new address after deselect
// R9: inputs captured only while clock gate low
// R10: three chip selects sampled jointly each edge
// R11: output enable asynchronous, combined with internal state
// R12: enable low, unmasked: data pins drive
// R13: enable high: pins released, used as input
// R14: outputs off in write data, deselect, emergence
// R15: clock gate high holds cycle, stays selected
// R16: read shows location addressed at previous edge
// R17: burst order linear on low strap, else interleaved
// R18: write data captured from pins on edge
// R19: selected only when all three selects true
`timescale 1ns/10ps
module ftbs_port #(
  parameter int ADDR_W = ftbs_pkg::ADDR_W,
  parameter int LANE_W = ftbs_pkg::LANE_W,
  parameter int LANES = ftbs_pkg::LANES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // synchronous command pins
  input wire logic clock_gate_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire ftbs_pkg::ftbs_ctl_t ctl,
  input wire logic [LANES-1:0] byte_lane_write_n,
  // burst order strap, caught while rst is high
  input wire logic burst_order,
  // asynchronous output enable
  input wire logic oe_n,
  // data pins, lane k holds its parity bit as the top bit
  input wire logic [LANE_W*LANES-1:0] dq_in,
  output logic [LANE_W*LANES-1:0] dq_out,
  output logic dq_oe
);
  localparam int BW = ftbs_pkg::BURST_W;
  localparam int DW = LANE_W * LANES;

  logic qual;
  logic sel;
  logic load;
  ftbs_pkg::ftbs_state_t state_r, state_nxt;
  logic [ADDR_W-1:0] base_r;
  logic [BW-1:0] cnt_r, cnt_nxt;
  logic [LANES-1:0] bw_n_r;
  logic linear_r;
  logic drive_r;
  logic [ADDR_W-1:0] cur_addr, nxt_addr;
  logic [DW-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DW-1:0] rd_word;
  logic wr_now;

  // burst position from start bits and count
  function automatic logic [BW-1:0] burst_lo(input logic [BW-1:0] start,
                                            input logic [BW-1:0] cnt,
                                            input logic linear);
    burst_lo = linear ? BW'(start + cnt) : (start ^ cnt);
  endfunction

  assign qual = ~clock_gate_n; // R9
  // all three selects must agree on the same edge
  assign sel = ~ctl.chip_select_first_n & ctl.chip_select_second
             & ~ctl.chip_select_third_n; // R10 R19
  assign load = ~ctl.advance_or_load; // R7
  assign wr_now = qual & (state_r == ftbs_pkg::FTBS_WRITE);

  // next command state and burst count
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = ftbs_pkg::CNT_RST;
      if (!sel) begin
        state_nxt = ftbs_pkg::FTBS_DESEL;
      end else if (!ctl.write_strobe_n) begin
        state_nxt = ftbs_pkg::FTBS_WRITE; // R4 R5
      end else begin
        state_nxt = ftbs_pkg::FTBS_READ;
      end
    end else if (state_r != ftbs_pkg::FTBS_DESEL) begin
      // advance while deselected does nothing until a load
      cnt_nxt = BW'(cnt_r + ftbs_pkg::BURST_STEP); // R6 R8
    end
  end

  // addresses of the current and the next access
  assign cur_addr = {base_r[ADDR_W-1:BW], burst_lo(base_r[BW-1:0], cnt_r, linear_r)};
  assign nxt_addr = load ? addr
                  : {base_r[ADDR_W-1:BW], burst_lo(base_r[BW-1:0], cnt_nxt, linear_r)}; // R2

  // strap caught during reset, held afterwards
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      linear_r <= ~burst_order; // R17
    end
  end

  // command pipeline, frozen while the clock is gated off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ftbs_pkg::FTBS_DESEL;
      cnt_r <= ftbs_pkg::CNT_RST;
      base_r <= '0;
      bw_n_r <= '1;
    end else if (qual) begin // R15
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (load) begin
        base_r <= addr; // R1
      end
      // lanes only count when the write strobe is low on this edge
      bw_n_r <= ctl.write_strobe_n ? '1 : byte_lane_write_n; // R3
    end
  end

  // lane writes land one edge after the write command; one process owns the whole array
  always_ff @(posedge ref_clk) begin
    for (int j = 0; j < LANES; j++) begin
      if (wr_now && !bw_n_r[j]) begin
        mem[cur_addr][j*LANE_W +: LANE_W] <= dq_in[j*LANE_W +: LANE_W]; // R18
      end
    end
  end

  // per-lane read merge, so a read right behind a write sees it
  genvar k;
  generate
    for (k = 0; k < LANES; k++) begin : g_lane
      assign rd_word[k*LANE_W +: LANE_W] =
        (wr_now && !bw_n_r[k] && cur_addr == nxt_addr) ? dq_in[k*LANE_W +: LANE_W]
                                                      : mem[nxt_addr][k*LANE_W +: LANE_W];
    end
  endgenerate

  // read data registered on the edge that takes the read address
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dq_out <= '0;
    end else if (qual && state_nxt == ftbs_pkg::FTBS_READ) begin
      dq_out <= rd_word; // R16
    end
  end

  // drive only in a read data cycle; never in write data or deselect
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      drive_r <= 1'b0;
    end else if (qual) begin
      drive_r <= (state_nxt == ftbs_pkg::FTBS_READ); // R14
    end
  end

  // pin enable is asynchronous in oe_n by intent, so it cannot be a plain flop
  assign dq_oe = drive_r & ~oe_n; // R11 R12 R13

  sequence s_read_cmd;
    qual && load && sel && ctl.write_strobe_n;
  endsequence

  sequence s_write_cmd;
    qual && load && sel && !ctl.write_strobe_n;
  endsequence

  a_read_drive: assert property (@(posedge ref_clk) disable iff (rst) // R12 R16
    s_read_cmd |=> drive_r)
    else $error("read not driven next cycle");

  a_write_quiet: assert property (@(posedge ref_clk) disable iff (rst) // R14
    s_write_cmd |=> !dq_oe)
    else $error("pins driven in write data phase");

  a_desel_quiet: assert property (@(posedge ref_clk) disable iff (rst) // R14 R19
    qual && load && !sel |=> !dq_oe && state_r == ftbs_pkg::FTBS_DESEL)
    else $error("pins driven while deselected");

  a_oe_high_off: assert property (@(posedge ref_clk) disable iff (rst) // R13
    oe_n |-> !dq_oe)
    else $error("pins driven with enable high");

  a_gate_hold: assert property (@(posedge ref_clk) disable iff (rst) // R9 R15
    !qual |=> $stable(state_r) && $stable(cnt_r) && $stable(dq_out))
    else $error("state moved while clock gated");

  a_burst_step: assert property (@(posedge ref_clk) disable iff (rst) // R6
    qual && !load && state_r != ftbs_pkg::FTBS_DESEL |=> cnt_r == BW'($past(cnt_r) + 1))
    else $error("burst counter did not step");

  a_load_addr: assert property (@(posedge ref_clk) disable iff (rst) // R1 R7
    qual && load |=> base_r == $past(addr) && cnt_r == ftbs_pkg::CNT_RST)
    else $error("address not loaded");

  a_lane_mask: assert property (@(posedge ref_clk) disable iff (rst) // R3 R4
    qual && ctl.write_strobe_n |=> bw_n_r == '1)
    else $error("lanes armed without write strobe");

  a_read_burst: assert property (@(posedge ref_clk) disable iff (rst) // R2 R16
    s_read_cmd ##1 (qual && !load) |=> drive_r && state_r == ftbs_pkg::FTBS_READ)
    else $error("read burst lost drive");

  a_desel_off: assert property (@(posedge ref_clk) disable iff (rst) // R14
    state_r == ftbs_pkg::FTBS_DESEL |-> !dq_oe)
    else $error("pins driven in deselect state");

  a_strap_catch: assert property (@(posedge ref_clk) // R17
    rst |=> linear_r == !$past(burst_order))
    else $error("burst order strap not caught");

  a_write_land: assert property (@(posedge ref_clk) disable iff (rst) // R18
    wr_now && !bw_n_r[0] |=> mem[$past(cur_addr)][LANE_W-1:0] == $past(dq_in[LANE_W-1:0]))
    else $error("write data not stored");
endmodule
